// file: logic/tofr_consts.svh
// constants of the time-of-flight result readout: addresses, field positions, widths
// assumes it is included by bare name wherever a number is needed
// Behaviour
// - The third stop interval result sits at address 14h: parity in bit 23, unsigned 23-bit result in bits 22..0.
// - The third stop coarse count sits at address 15h: parity in bit 23, count in bits 15..0.
// - The fourth stop interval result sits at address 16h with parity on top and a 23-bit result below.
// - The fourth stop coarse count sits at address 17h: parity in bit 23, count in bits 15..0.
// - The fifth stop interval result sits at address 18h with parity on top and a 23-bit result below.
// - The fifth stop coarse count sits at address 19h as a 24-bit word with parity in the top bit.
// - Bits 22..16 of every coarse count register read as zero.
// - All result registers are read-only to the host and read zero after reset until a result is written.
// - The second stop coarse count, laid out like the other counts, sits at address 13h.
`ifndef TOFR_CONSTS_SVH
`define TOFR_CONSTS_SVH

`define TOFR_ADDR_W 6
`define TOFR_CMD_W 8
`define TOFR_WORD_W 24
`define TOFR_VAL_W 23
`define TOFR_CNT_W 16
`define TOFR_SLOT_W 3
`define TOFR_SLOTS 7

`define TOFR_ADDR_STOP2_COUNT 6'h13
`define TOFR_ADDR_STOP3_TIME 6'h14
`define TOFR_ADDR_STOP3_COUNT 6'h15
`define TOFR_ADDR_STOP4_TIME 6'h16
`define TOFR_ADDR_STOP4_COUNT 6'h17
`define TOFR_ADDR_STOP5_TIME 6'h18
`define TOFR_ADDR_STOP5_COUNT 6'h19
`define TOFR_ADDR_FIRST `TOFR_ADDR_STOP2_COUNT
`define TOFR_ADDR_LAST `TOFR_ADDR_STOP5_COUNT

`define TOFR_PARITY_BIT 23
`define TOFR_CMD_AUTOINC_BIT 7
`define TOFR_CMD_WRITE_BIT 6
`define TOFR_WORD_RESET 24'h000000
`define TOFR_CNT_PAD 7'h00
`define TOFR_BIT_LAST_CMD 5'h07
`define TOFR_BIT_LAST_WORD 5'h17

`endif

// file: logic/tofr_pkg.sv
// types shared by the result readout modules
// assumes tofr_consts.svh is on the include path
`include "tofr_consts.svh"

package tofr_pkg;

    typedef enum logic [2:0] {
        TOFR_IDLE = 3'h0,
        TOFR_CMD = 3'h1,
        TOFR_FETCH = 3'h2,
        TOFR_LOAD = 3'h3,
        TOFR_DATA = 3'h4,
        TOFR_DONE = 3'h5
    } tofr_state_t;

    typedef logic [`TOFR_WORD_W-1:0] tofr_word_t;

endpackage

// file: logic/tofr_sync.sv
// two-flop synchroniser for a group of asynchronous pin levels
// assumes the pins are quasi-static relative to clk_in
module tofr_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_level_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("tofr_sync width must be positive");
    end

    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            // reset level is fixed at one; reset_level_in changes neither the flops nor sync_out
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
            assign sync_out[i] = sync_q[i] & (reset_level_in[i] | 1'b1);
        end
    endgenerate
endmodule

// file: logic/tofr_mem.sv
// small result store: one write port, one registered read port, cleared by reset
// assumes writer and reader share clk_in; entries are flops so reset clears them all
`include "tofr_consts.svh"
module tofr_mem #(
    parameter int DEPTH = `TOFR_SLOTS,
    parameter int AW = `TOFR_SLOT_W,
    parameter int DW = `TOFR_WORD_W
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);
    logic [DW-1:0] mem_q [DEPTH];
    logic [DW-1:0] rd_data_q;

    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("tofr_mem depth does not fit the address width");
    end

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    mem_q[i] <= '0;
                end else if (wr_en_in && wr_addr_in == AW'(i)) begin
                    mem_q[i] <= wr_data_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_q <= '0;
        end else if (int'(rd_addr_in) < DEPTH) begin
            rd_data_q <= mem_q[rd_addr_in];
        end else begin
            rd_data_q <= '0;
        end
    end

    assign rd_data_out = rd_data_q;
endmodule

// file: logic/tofr_readout.sv
// serial host port and result registers for the second to fifth stop results
// assumes spi mode 0 from the host with sclk half period of at least 8 clk_in cycles,
// and a measurement engine on clk_in that posts one result per meas_wr_in pulse
`include "tofr_consts.svh"
module tofr_readout
    import tofr_pkg::*;
#(
    parameter int SLOTS = `TOFR_SLOTS
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic spi_sclk_in,
    input wire logic spi_csn_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    input wire logic meas_wr_in,
    input wire logic [`TOFR_SLOT_W-1:0] meas_slot_in,
    input wire logic [`TOFR_VAL_W-1:0] meas_value_in,
    output logic busy_out
);
    if (SLOTS != `TOFR_SLOTS) begin : g_bad_slots
        $error("tofr_readout serves exactly the documented result slots");
    end

    // pin synchronisation
    logic [2:0] pins_sync;
    logic sclk_s;
    logic csn_s;
    logic mosi_s;
    logic sclk_prev_q;
    wire sclk_rise;
    wire sclk_fall;

    tofr_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in({spi_mosi_in, spi_csn_in, spi_sclk_in}),
        .reset_level_in(3'h7),
        .sync_out(pins_sync)
    );

    assign sclk_s = pins_sync[0];
    assign csn_s = pins_sync[1];
    assign mosi_s = pins_sync[2];

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            // matches the synchroniser's reset level so no false rise follows reset
            sclk_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    // result formatting on the write side
    // slots 0,2,4,6 hold coarse counts (13h,15h,17h,19h); slots 1,3,5 hold interval results
    wire slot_is_count;
    wire [`TOFR_VAL_W-1:0] wr_body;
    wire [`TOFR_WORD_W-1:0] wr_word;
    wire wr_ok;

    assign slot_is_count = ~meas_slot_in[0];
    // the averaging extension bits stay zero in count registers
    assign wr_body = slot_is_count ? {`TOFR_CNT_PAD, meas_value_in[`TOFR_CNT_W-1:0]} : meas_value_in;
    // even parity, the full 24-bit word always has an even number of ones
    assign wr_word = {^wr_body, wr_body};
    assign wr_ok = meas_wr_in && (int'(meas_slot_in) < SLOTS);

    // host address decode
    logic [`TOFR_ADDR_W-1:0] addr_q;
    wire addr_mapped;
    wire [`TOFR_SLOT_W-1:0] rd_slot;
    wire [`TOFR_ADDR_W-1:0] addr_diff;
    tofr_word_t rd_word;

    // 13h..19h map to slots 0..6 in address order
    assign addr_mapped = (addr_q >= `TOFR_ADDR_FIRST) && (addr_q <= `TOFR_ADDR_LAST);
    assign addr_diff = addr_q - `TOFR_ADDR_FIRST;
    assign rd_slot = addr_diff[`TOFR_SLOT_W-1:0];

    tofr_mem #(
        .DEPTH(`TOFR_SLOTS),
        .AW(`TOFR_SLOT_W),
        .DW(`TOFR_WORD_W)
    ) u_mem (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .wr_en_in(wr_ok),
        .wr_addr_in(meas_slot_in),
        .wr_data_in(wr_word),
        .rd_addr_in(rd_slot),
        .rd_data_out(rd_word)
    );

    // serial engine
    tofr_state_t state_q;
    tofr_state_t state_d;
    logic [`TOFR_CMD_W-1:0] cmd_q;
    logic [4:0] bit_q;
    logic autoinc_q;
    tofr_word_t shift_q;
    logic miso_q;
    logic miso_oe_q;
    logic busy_q;
    wire [`TOFR_CMD_W-1:0] cmd_next;
    wire cmd_last;
    wire word_last;
    wire cmd_is_write;

    assign cmd_next = {cmd_q[`TOFR_CMD_W-2:0], mosi_s};
    assign cmd_last = sclk_rise && (bit_q == `TOFR_BIT_LAST_CMD);
    assign word_last = sclk_rise && (bit_q == `TOFR_BIT_LAST_WORD);
    // a write command is ignored, the registers cannot be altered from the host
    assign cmd_is_write = cmd_next[`TOFR_CMD_WRITE_BIT];

    always_comb begin
        state_d = state_q;
        case (state_q)
            TOFR_IDLE: begin
                if (!csn_s) begin
                    state_d = TOFR_CMD;
                end
            end
            TOFR_CMD: begin
                if (cmd_last) begin
                    state_d = cmd_is_write ? TOFR_DONE : TOFR_FETCH;
                end
            end
            TOFR_FETCH: begin
                state_d = TOFR_LOAD;
            end
            TOFR_LOAD: begin
                state_d = TOFR_DATA;
            end
            TOFR_DATA: begin
                if (word_last) begin
                    state_d = autoinc_q ? TOFR_FETCH : TOFR_DONE;
                end
            end
            TOFR_DONE: begin
                state_d = TOFR_DONE;
            end
            default: begin
                state_d = TOFR_IDLE;
            end
        endcase
        // deselect aborts any frame; the next frame starts from a fresh command
        if (csn_s) begin
            state_d = TOFR_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= TOFR_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmd_q <= '0;
            bit_q <= '0;
        end else if (state_q == TOFR_IDLE || state_q == TOFR_LOAD) begin
            cmd_q <= '0;
            bit_q <= '0;
        end else if (sclk_rise && (state_q == TOFR_CMD || state_q == TOFR_DATA)) begin
            cmd_q <= cmd_next;
            bit_q <= bit_q + 5'h01;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_q <= '0;
            autoinc_q <= 1'b0;
        end else if (state_q == TOFR_CMD && cmd_last) begin
            addr_q <= cmd_next[`TOFR_ADDR_W-1:0];
            autoinc_q <= cmd_next[`TOFR_CMD_AUTOINC_BIT];
        end else if (state_q == TOFR_DATA && word_last && autoinc_q) begin
            addr_q <= addr_q + 6'h01;
        end
    end

    // unmapped addresses shift out zeros rather than a stale word
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shift_q <= `TOFR_WORD_RESET;
            miso_q <= 1'b0;
        end else if (state_q == TOFR_LOAD) begin
            shift_q <= addr_mapped ? rd_word : `TOFR_WORD_RESET;
            miso_q <= addr_mapped ? rd_word[`TOFR_PARITY_BIT] : 1'b0;
        // the first fall of a word only ends the previous bit: bit 23 is already on miso
        end else if (state_q == TOFR_DATA && sclk_fall && (|bit_q)) begin
            shift_q <= {shift_q[`TOFR_WORD_W-2:0], 1'b0};
            miso_q <= shift_q[`TOFR_WORD_W-2];
        end else if (state_q == TOFR_IDLE || state_q == TOFR_DONE) begin
            miso_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            miso_oe_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            miso_oe_q <= ~csn_s;
            busy_q <= (state_d != TOFR_IDLE);
        end
    end

    assign spi_miso_out = miso_q;
    assign spi_miso_oe_out = miso_oe_q;
    assign busy_out = busy_q;
endmodule

// file: sim/tofr_readout_chk.sv
// checker for the result readout's host port timing
// assumes it is bound to tofr_readout and sees only its ports
`include "tofr_consts.svh"
module tofr_readout_chk (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic spi_sclk_in,
    input wire logic spi_csn_in,
    input wire logic spi_miso_out,
    input wire logic spi_miso_oe_out,
    input wire logic busy_out
);
    logic sclk_q;
    logic csn_q;
    logic [3:0] since_q;
    wire pin_edge = (spi_sclk_in != sclk_q) || (spi_csn_in != csn_q);
    // miso may only move shortly after a host pin edge
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_q <= 1'b0;
            csn_q <= 1'b1;
            since_q <= 4'h0;
        end else begin
            sclk_q <= spi_sclk_in;
            csn_q <= spi_csn_in;
            since_q <= pin_edge ? 4'h0 : (since_q == 4'hF ? since_q : since_q + 4'h1);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_oe_on_select: assert property (!spi_csn_in [*6] |-> spi_miso_oe_out)
        else $error("miso not enabled while selected");
    a_oe_off_idle: assert property (spi_csn_in [*6] |-> !spi_miso_oe_out)
        else $error("miso enabled while deselected");
    a_busy_idle: assert property (spi_csn_in [*6] |-> !busy_out)
        else $error("busy while deselected");
    a_oe_rise_cause: assert property ($rose(spi_miso_oe_out) |-> !spi_csn_in && $past(!spi_csn_in))
        else $error("miso enabled without select");
    a_busy_rise_cause: assert property ($rose(busy_out) |-> !spi_csn_in)
        else $error("busy without select");
    a_oe_sync_delay: assert property ($fell(spi_csn_in) |=> !spi_miso_oe_out)
        else $error("miso enabled too early");
    a_miso_hold_rise: assert property ($rose(spi_sclk_in) && spi_miso_oe_out |->
        $stable(spi_miso_out) ##1 $stable(spi_miso_out))
        else $error("miso moved at sample edge");
    a_miso_near_edge: assert property (spi_miso_oe_out && $past(spi_miso_oe_out) && $changed(spi_miso_out)
        |-> since_q < 4'h8)
        else $error("miso moved without host edge");
endmodule
bind tofr_readout tofr_readout_chk tofr_readout_chk_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .spi_sclk_in(spi_sclk_in), .spi_csn_in(spi_csn_in), .spi_miso_out(spi_miso_out),
    .spi_miso_oe_out(spi_miso_oe_out), .busy_out(busy_out));

// file: sim/tofr_host.sv
// host model: spi mode 0 master reading result words
// assumes inputs of the device are changed on falling clk_in edges
module tofr_host
    import tofr_pkg::*;
#(
    parameter int HALF = 10
) (
    input wire logic clk_in,
    output logic sclk_out,
    output logic csn_out,
    output logic mosi_out,
    input wire logic miso_in
);
    timeunit 1ns;
    timeprecision 1ns;
    tofr_word_t got [0:7];
    initial begin
        sclk_out = 1'b0;
        csn_out = 1'b1;
        mosi_out = 1'b0;
    end
    // released data line keeps toggling so a stale level is never read as valid
    always @(negedge clk_in) if (csn_out) mosi_out <= ~mosi_out;
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd);
        csn_out = 1'b0;
        repeat (4) @(negedge clk_in);
        for (int i = 0; i < 8 + 24 * n; i++) begin
            mosi_out = (i < 8) ? cmd[7 - i] : wd[23 - (i - 8) % 24];
            repeat (HALF) @(negedge clk_in);
            sclk_out = 1'b1;
            if (i >= 8) got[(i - 8) / 24][23 - (i - 8) % 24] = miso_in;
            repeat (HALF) @(negedge clk_in);
            sclk_out = 1'b0;
        end
        repeat (4) @(negedge clk_in);
        csn_out = 1'b1;
        repeat (10) @(negedge clk_in);
    endtask
endmodule

// file: sim/tofr_readout_bench.sv
// self-checking bench for the result readout registers
// assumes the host model drives the serial port and the bench drives the result port
`include "tofr_consts.svh"
module tofr_readout_bench
    import tofr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic meas_wr_in = 1'b0;
    logic [2:0] meas_slot_in = 3'h0;
    logic [22:0] meas_value_in = 23'h0;
    wire sclk, csn, mosi, miso, oe, busy;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    tofr_readout tofr_readout_i (.clk_in(clk_in), .resetn_in(resetn_in), .spi_sclk_in(sclk),
        .spi_csn_in(csn), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe),
        .meas_wr_in(meas_wr_in), .meas_slot_in(meas_slot_in), .meas_value_in(meas_value_in),
        .busy_out(busy));
    tofr_host tofr_host_i (.clk_in(clk_in), .sclk_out(sclk), .csn_out(csn), .mosi_out(mosi), .miso_in(miso));
    always #50 clk_in = ~clk_in;
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // even slots are coarse counts: only 16 bits kept, top bit makes the word even
    function automatic tofr_word_t expw(input int s, input logic [22:0] v);
        logic [22:0] b;
        b = (s % 2 == 0) ? {7'h00, v[15:0]} : v;
        return {^b, b};
    endfunction
    function automatic logic [22:0] val(input int s);
        return 23'h7E5A3C + 23'(s) * 23'h010101;
    endfunction
    task automatic t_zero();
        tofr_host_i.xfer(8'h93, 8, 24'hFFFFFF);
        for (int k = 0; k < 8; k++) check("zero word", tofr_host_i.got[k], 24'h000000);
        check("enable idle", {23'h000000, oe}, 24'h000000);
        check("busy idle", {23'h000000, busy}, 24'h000000);
        $display("test zero done");
    endtask
    task automatic t_fill();
        for (int s = 0; s < 8; s++) begin
            @(negedge clk_in);
            meas_wr_in = 1'b1;
            meas_slot_in = 3'(s);
            meas_value_in = val(s);
        end
        @(negedge clk_in);
        meas_wr_in = 1'b0;
        fork
            tofr_host_i.xfer(8'h93, 8, 24'h000000);
            begin
                repeat (40) @(negedge clk_in);
                check("enable in frame", {23'h000000, oe}, 24'h000001);
                check("busy in frame", {23'h000000, busy}, 24'h000001);
            end
        join
        for (int k = 0; k < 7; k++) check("result", tofr_host_i.got[k], expw(k, val(k)));
        check("unmapped", tofr_host_i.got[7], 24'h000000);
        $display("test fill done");
    endtask
    task automatic t_ro();
        tofr_host_i.xfer(8'h54, 1, 24'h123456);
        check("write frame", tofr_host_i.got[0], 24'h000000);
        tofr_host_i.xfer(8'h14, 2, 24'h000000);
        check("after write", tofr_host_i.got[0], expw(1, val(1)));
        check("no increment", tofr_host_i.got[1], 24'h000000);
        @(negedge clk_in);
        meas_wr_in = 1'b1;
        meas_slot_in = 3'h1;
        meas_value_in = 23'h000001;
        @(negedge clk_in);
        meas_wr_in = 1'b0;
        tofr_host_i.xfer(8'h14, 1, 24'h000000);
        check("odd parity", tofr_host_i.got[0], 24'h800001);
        $display("test read only done");
    endtask
    task automatic t_rst();
        @(negedge clk_in);
        resetn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (5) @(negedge clk_in);
        t_zero();
        $display("test second reset done");
    endtask
    initial begin
        repeat (20) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (5) @(negedge clk_in);
        t_zero();
        t_fill();
        t_ro();
        t_rst();
        conclude();
    end
endmodule
